// File: logic/ppsc_pkg.sv
// Shared types and constants for the package power state controller.
package ppsc_pkg;
    localparam int NUM_CORES = 4;
    localparam int CSTATE_W = 3;
    localparam int SLEEP_W = 2;
    localparam int MEM_W = 2;

    typedef enum logic [2:0] {
        CST_C0 = 3'h0,
        CST_C1 = 3'h1,
        CST_C1E = 3'h2,
        CST_C3 = 3'h3,
        CST_C6 = 3'h4,
        CST_C7 = 3'h5
    } ppsc_cstate_type;

    typedef enum logic [1:0] {
        SLP_S0 = 2'h0,
        SLP_S3 = 2'h1,
        SLP_S4 = 2'h2,
        SLP_S5 = 2'h3
    } ppsc_sleep_type;

    typedef enum logic [1:0] {
        MEM_POWER_UP = 2'h0,
        MEM_PRECHARGE_PD = 2'h1,
        MEM_ACTIVE_PD = 2'h2,
        MEM_SELF_REFRESH = 2'h3
    } ppsc_mem_type;

    typedef enum logic [2:0] {
        CS_RUN = 3'h0,
        CS_HALT = 3'h1,
        CS_FLUSH = 3'h2,
        CS_GATED = 3'h3,
        CS_SAVE = 3'h4,
        CS_OFF = 3'h5
    } ppsc_core_fsm_type;

    typedef enum logic [1:0] {
        LLC_ON = 2'h0,
        LLC_FLUSHING = 2'h1,
        LLC_OFF = 2'h2
    } ppsc_llc_type;
endpackage

// File: logic/ppsc_core_seq.sv
// Per-core idle sequencer: halt, cache write-back, clock gating, state save and power-off.
`timescale 1ns/1ps
module ppsc_core_seq (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] req_i,
    input wire logic flush_done_i,
    input wire logic save_done_i,
    output logic [2:0] state_o,
    output logic flush_req_o,
    output logic clk_gate_o,
    output logic save_req_o,
    output logic pwr_off_o
);
    ppsc_pkg::ppsc_core_fsm_type fsm_reg, fsm_next;
    logic [2:0] tgt_reg, tgt_next;
    logic [2:0] state_next;
    logic flush_next, gate_next, save_next, off_next;

    always_comb
    begin
        fsm_next = fsm_reg;
        tgt_next = tgt_reg;
        if (req_i == ppsc_pkg::CST_C0)
        begin
            fsm_next = ppsc_pkg::CS_RUN;
        end
        else
        begin
            unique case (fsm_reg)
                ppsc_pkg::CS_RUN:
                begin
                    tgt_next = req_i;
                    if (req_i == ppsc_pkg::CST_C1 || req_i == ppsc_pkg::CST_C1E)
                        fsm_next = ppsc_pkg::CS_HALT;
                    else
                        fsm_next = ppsc_pkg::CS_FLUSH;
                end
                ppsc_pkg::CS_HALT:
                    // A deeper request must pass C0 first, so only C1 and C1E trade places.
                    if (req_i == ppsc_pkg::CST_C1 || req_i == ppsc_pkg::CST_C1E)
                        tgt_next = req_i;
                ppsc_pkg::CS_FLUSH:
                    if (flush_done_i)
                        fsm_next = (tgt_reg == ppsc_pkg::CST_C3) ? ppsc_pkg::CS_GATED
                                                                 : ppsc_pkg::CS_SAVE;
                ppsc_pkg::CS_GATED:
                    fsm_next = ppsc_pkg::CS_GATED;
                ppsc_pkg::CS_SAVE:
                    if (save_done_i)
                        fsm_next = ppsc_pkg::CS_OFF;
                ppsc_pkg::CS_OFF:
                    tgt_next = (req_i == ppsc_pkg::CST_C7) ? ppsc_pkg::CST_C7
                                                           : ppsc_pkg::CST_C6;
                default:
                    fsm_next = ppsc_pkg::CS_RUN;
            endcase
        end
        // Outputs follow the next state so each one leaves a flip-flop.
        flush_next = (fsm_next == ppsc_pkg::CS_FLUSH);
        gate_next = (fsm_next == ppsc_pkg::CS_GATED) || (fsm_next == ppsc_pkg::CS_SAVE)
                    || (fsm_next == ppsc_pkg::CS_OFF) || (fsm_next == ppsc_pkg::CS_HALT);
        save_next = (fsm_next == ppsc_pkg::CS_SAVE);
        off_next = (fsm_next == ppsc_pkg::CS_OFF);
        unique case (fsm_next)
            ppsc_pkg::CS_HALT: state_next = tgt_next;
            ppsc_pkg::CS_GATED: state_next = ppsc_pkg::CST_C3;
            ppsc_pkg::CS_OFF: state_next = tgt_next;
            default: state_next = ppsc_pkg::CST_C0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fsm_reg <= ppsc_pkg::CS_RUN;
            tgt_reg <= ppsc_pkg::CST_C0;
            state_o <= ppsc_pkg::CST_C0;
            flush_req_o <= 1'b0;
            clk_gate_o <= 1'b0;
            save_req_o <= 1'b0;
            pwr_off_o <= 1'b0;
        end
        else
        begin
            fsm_reg <= fsm_next;
            tgt_reg <= tgt_next;
            state_o <= state_next;
            flush_req_o <= flush_next;
            clk_gate_o <= gate_next;
            save_req_o <= save_next;
            pwr_off_o <= off_next;
        end
    end

    property p_c3_after_flush;
        @(posedge clk_i) disable iff (!rst_n_i)
        (fsm_reg == ppsc_pkg::CS_FLUSH && flush_done_i && tgt_reg == ppsc_pkg::CST_C3
         && req_i != ppsc_pkg::CST_C0) |=> (clk_gate_o && state_o == ppsc_pkg::CST_C3);
    endproperty
    a_c3_after_flush: assert property (p_c3_after_flush)
        else $error("C3 gate did not follow the cache write-back.");

    property p_off_after_save;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(pwr_off_o) |-> $past(save_req_o) && $past(save_done_i);
    endproperty
    a_off_after_save: assert property (p_off_after_save)
        else $error("Core voltage removed before state save completed.");
endmodule

// File: logic/ppsc_top.sv
// Package power state controller: core idle, cache, memory, graphics, sleep and interrupt steering.
`timescale 1ns/1ps
// What this block does
// - C3 writes back core caches, then gates clocks.
// - C6 saves state before core voltage removal.
// - C7 like C6; all-C7 starts LLC flush.
// - LLC voltage removed only after full flush.
// - C1 halts; C1E also lowest operating point.
// - Memory powered-up mode keeps CKE asserted.
// - Pre-charge power-down: CKE low, banks closed.
// - Active power-down: CKE low, bank open.
// - Self-refresh drops CKE, DRAM refreshes itself.
// - Suspend-to-RAM cold only; hot variant refused.
// - Suspend-to-disk removes all package power.
// - Soft-off removes power; leaving needs reboot.
// - Graphics D3 in S3: display off, core off.
// - Energy routing targets active; deep idle core 0 only if none in C0-C1E.
// - Performance routing prefers C1 cores over busy.
module ppsc_top #(
    parameter int NUM_CORES = ppsc_pkg::NUM_CORES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3*NUM_CORES-1:0] core_req_i,
    input wire logic [NUM_CORES-1:0] core_flush_done_i,
    input wire logic [NUM_CORES-1:0] core_save_done_i,
    input wire logic [NUM_CORES-1:0] core_busy_i,
    input wire logic llc_empty_i,
    input wire logic sleep_req_valid_i,
    input wire logic [1:0] sleep_req_i,
    input wire logic s3_hot_req_i,
    input wire logic wake_i,
    input wire logic mem_idle_req_i,
    input wire logic mem_sr_req_i,
    input wire logic banks_open_i,
    input wire logic gfx_d3_i,
    input wire logic irq_valid_i,
    input wire logic irq_perf_mode_i,
    output logic [3*NUM_CORES-1:0] core_state_o,
    output logic [NUM_CORES-1:0] core_flush_req_o,
    output logic [NUM_CORES-1:0] core_clk_gate_o,
    output logic [NUM_CORES-1:0] core_save_req_o,
    output logic [NUM_CORES-1:0] core_pwr_off_o,
    output logic llc_flush_req_o,
    output logic llc_pwr_off_o,
    output logic low_vf_o,
    output logic [2:0] pkg_cstate_o,
    output logic [1:0] sleep_state_o,
    output logic pkg_pwr_off_o,
    output logic reboot_req_o,
    output logic s3_hot_reject_o,
    output logic [1:0] mem_mode_o,
    output logic dram_cke_o,
    output logic sys_clk_on_o,
    output logic display_on_o,
    output logic gfx_pwr_off_o,
    output logic irq_valid_o,
    output logic [NUM_CORES-1:0] irq_target_o
);
    logic rst_meta_reg, rst_n_reg;

    // Release is synchronised so all state leaves reset on the same edge.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    function automatic logic [NUM_CORES-1:0] first_of(input logic [NUM_CORES-1:0] mask);
        logic [NUM_CORES-1:0] pick;
        pick = '0;
        for (int i = NUM_CORES - 1; i >= 0; i--)
        begin
            if (mask[i])
                pick = '0;
            if (mask[i])
                pick[i] = 1'b1;
        end
        return pick;
    endfunction

    for (genvar g = 0; g < NUM_CORES; g++)
    begin : g_core
        ppsc_core_seq u_seq (
            .clk_i(clk_i),
            .rst_n_i(rst_n_reg),
            .req_i(core_req_i[3*g +: 3]),
            .flush_done_i(core_flush_done_i[g]),
            .save_done_i(core_save_done_i[g]),
            .state_o(core_state_o[3*g +: 3]),
            .flush_req_o(core_flush_req_o[g]),
            .clk_gate_o(core_clk_gate_o[g]),
            .save_req_o(core_save_req_o[g]),
            .pwr_off_o(core_pwr_off_o[g])
        );
    end

    ppsc_pkg::ppsc_llc_type llc_reg, llc_next;
    ppsc_pkg::ppsc_sleep_type sleep_reg, sleep_next, pend_reg, pend_next;
    logic [NUM_CORES-1:0] active_m, light_m, all_c7_m;
    logic all_c7;
    logic [2:0] pkg_next;
    logic [1:0] mem_next;
    logic s3_rej_next, irq_v_next;
    logic [NUM_CORES-1:0] irq_t_next;

    always_comb
    begin
        pkg_next = ppsc_pkg::CST_C7;
        for (int i = 0; i < NUM_CORES; i++)
        begin
            active_m[i] = (core_state_o[3*i +: 3] == ppsc_pkg::CST_C0);
            light_m[i] = (core_state_o[3*i +: 3] == ppsc_pkg::CST_C1)
                         || (core_state_o[3*i +: 3] == ppsc_pkg::CST_C1E);
            all_c7_m[i] = (core_req_i[3*i +: 3] == ppsc_pkg::CST_C7) && core_pwr_off_o[i];
            if (core_state_o[3*i +: 3] < pkg_next)
                pkg_next = core_state_o[3*i +: 3];
        end
        all_c7 = &all_c7_m;
        llc_next = llc_reg;
        unique case (llc_reg)
            ppsc_pkg::LLC_ON:
                if (all_c7)
                    llc_next = ppsc_pkg::LLC_FLUSHING;
            ppsc_pkg::LLC_FLUSHING:
                if (!all_c7)
                    llc_next = ppsc_pkg::LLC_ON;
                else if (llc_empty_i)
                    llc_next = ppsc_pkg::LLC_OFF;
            ppsc_pkg::LLC_OFF:
                if (!all_c7)
                    llc_next = ppsc_pkg::LLC_ON;
            default:
                llc_next = ppsc_pkg::LLC_ON;
        endcase
        // Package C7 is only reported once the shared cache is really powered down.
        if (pkg_next == ppsc_pkg::CST_C7 && llc_next != ppsc_pkg::LLC_OFF)
            pkg_next = ppsc_pkg::CST_C6;

        sleep_next = sleep_reg;
        pend_next = pend_reg;
        s3_rej_next = s3_hot_req_i;
        if (sleep_reg == ppsc_pkg::SLP_S0 && pend_reg == ppsc_pkg::SLP_S0)
        begin
            if (sleep_req_valid_i && !s3_hot_req_i)
                pend_next = ppsc_pkg::ppsc_sleep_type'(sleep_req_i);
        end
        else if (pend_reg != ppsc_pkg::SLP_S0)
        begin
            // Suspend-to-RAM is entered only once DRAM holds the context in self-refresh.
            if (pend_reg != ppsc_pkg::SLP_S3 || mem_mode_o == ppsc_pkg::MEM_SELF_REFRESH)
            begin
                sleep_next = pend_reg;
                pend_next = ppsc_pkg::SLP_S0;
            end
        end
        else if (wake_i && sleep_reg != ppsc_pkg::SLP_S5)
            sleep_next = ppsc_pkg::SLP_S0;

        if (pend_reg == ppsc_pkg::SLP_S3 || sleep_reg == ppsc_pkg::SLP_S3 || mem_sr_req_i)
            mem_next = ppsc_pkg::MEM_SELF_REFRESH;
        else if (mem_idle_req_i && banks_open_i)
            mem_next = ppsc_pkg::MEM_ACTIVE_PD;
        else if (mem_idle_req_i)
            mem_next = ppsc_pkg::MEM_PRECHARGE_PD;
        else
            mem_next = ppsc_pkg::MEM_POWER_UP;

        irq_v_next = irq_valid_i;
        irq_t_next = '0;
        if (irq_valid_i)
        begin
            if (irq_perf_mode_i)
            begin
                if (|light_m)
                    irq_t_next = first_of(light_m);
                else if (|(active_m & ~core_busy_i))
                    irq_t_next = first_of(active_m & ~core_busy_i);
                else
                    irq_t_next = first_of(active_m);
            end
            else
            begin
                if (|active_m)
                    irq_t_next = first_of(active_m);
                else
                    irq_t_next = first_of(light_m);
            end
            // With every core in deep idle some core must still take the interrupt.
            if (irq_t_next == '0)
                irq_t_next[0] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            llc_reg <= ppsc_pkg::LLC_ON;
            sleep_reg <= ppsc_pkg::SLP_S0;
            pend_reg <= ppsc_pkg::SLP_S0;
            llc_flush_req_o <= 1'b0;
            llc_pwr_off_o <= 1'b0;
            low_vf_o <= 1'b0;
            pkg_cstate_o <= ppsc_pkg::CST_C0;
            sleep_state_o <= ppsc_pkg::SLP_S0;
            pkg_pwr_off_o <= 1'b0;
            reboot_req_o <= 1'b0;
            s3_hot_reject_o <= 1'b0;
            mem_mode_o <= ppsc_pkg::MEM_POWER_UP;
            dram_cke_o <= 1'b1;
            sys_clk_on_o <= 1'b1;
            display_on_o <= 1'b0;
            gfx_pwr_off_o <= 1'b0;
            irq_valid_o <= 1'b0;
            irq_target_o <= '0;
        end
        else
        begin
            llc_reg <= llc_next;
            sleep_reg <= sleep_next;
            pend_reg <= pend_next;
            llc_flush_req_o <= (llc_next == ppsc_pkg::LLC_FLUSHING);
            llc_pwr_off_o <= (llc_next == ppsc_pkg::LLC_OFF);
            low_vf_o <= (pkg_next >= ppsc_pkg::CST_C1E);
            pkg_cstate_o <= pkg_next;
            sleep_state_o <= sleep_next;
            pkg_pwr_off_o <= (sleep_next != ppsc_pkg::SLP_S0);
            reboot_req_o <= (sleep_next == ppsc_pkg::SLP_S5);
            s3_hot_reject_o <= s3_rej_next;
            mem_mode_o <= mem_next;
            dram_cke_o <= (mem_next == ppsc_pkg::MEM_POWER_UP);
            sys_clk_on_o <= (sleep_next == ppsc_pkg::SLP_S0);
            display_on_o <= (sleep_next == ppsc_pkg::SLP_S0) && !gfx_d3_i;
            gfx_pwr_off_o <= (sleep_next != ppsc_pkg::SLP_S0) && gfx_d3_i;
            irq_valid_o <= irq_v_next;
            irq_target_o <= irq_t_next;
        end
    end

    property p_llc_all_c7;
        @(posedge clk_i) disable iff (!rst_n_reg)
        $rose(llc_flush_req_o) |-> $past(all_c7);
    endproperty
    a_llc_all_c7: assert property (p_llc_all_c7)
        else $error("Cache flush began without every core in C7.");

    property p_llc_off_flushed;
        @(posedge clk_i) disable iff (!rst_n_reg)
        $rose(llc_pwr_off_o) |-> $past(llc_flush_req_o) && $past(llc_empty_i);
    endproperty
    a_llc_off_flushed: assert property (p_llc_off_flushed)
        else $error("Cache voltage removed before the flush finished.");

    property p_cke_up;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (mem_mode_o == ppsc_pkg::MEM_POWER_UP) == dram_cke_o;
    endproperty
    a_cke_up: assert property (p_cke_up)
        else $error("CKE disagrees with powered-up memory mode.");

    property p_precharge_pd;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (mem_idle_req_i && !banks_open_i && !mem_sr_req_i && pend_reg == ppsc_pkg::SLP_S0
         && sleep_reg == ppsc_pkg::SLP_S0) |=> (mem_mode_o == ppsc_pkg::MEM_PRECHARGE_PD);
    endproperty
    a_precharge_pd: assert property (p_precharge_pd)
        else $error("Closed banks did not give pre-charge power-down.");

    property p_active_pd;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (mem_mode_o == ppsc_pkg::MEM_ACTIVE_PD) |-> !dram_cke_o && $past(banks_open_i);
    endproperty
    a_active_pd: assert property (p_active_pd)
        else $error("Active power-down without an open bank.");

    property p_s3_hot;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (s3_hot_req_i && sleep_reg == ppsc_pkg::SLP_S0) |=> s3_hot_reject_o
            ##1 (sleep_state_o == ppsc_pkg::SLP_S0);
    endproperty
    a_s3_hot: assert property (p_s3_hot)
        else $error("Hot suspend-to-RAM request was not refused.");

    property p_s5_sticky;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (sleep_state_o == ppsc_pkg::SLP_S5) |=> (sleep_state_o == ppsc_pkg::SLP_S5)[*3];
    endproperty
    a_s5_sticky: assert property (p_s5_sticky)
        else $error("Soft-off left without a reboot.");

    property p_energy_route;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (irq_valid_i && !irq_perf_mode_i && |active_m) |=> |(irq_target_o & $past(active_m));
    endproperty
    a_energy_route: assert property (p_energy_route)
        else $error("Energy routing woke an idle core.");

    property p_perf_route;
        @(posedge clk_i) disable iff (!rst_n_reg)
        (irq_valid_i && irq_perf_mode_i && |light_m) |=> |(irq_target_o & $past(light_m));
    endproperty
    a_perf_route: assert property (p_perf_route)
        else $error("Performance routing skipped a halted core.");
endmodule

// File: verification/ppsc_far_model.sv
// Far-side model: core caches, state save memory and shared cache answering the controller.
`timescale 1ns/1ps
module ppsc_far_model #(
    parameter int NUM_CORES = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic [NUM_CORES-1:0] flush_req_i,
    input wire logic [NUM_CORES-1:0] save_req_i,
    input wire logic llc_flush_req_i,
    input wire logic llc_pwr_off_i,
    output logic [NUM_CORES-1:0] flush_done_o,
    output logic [NUM_CORES-1:0] save_done_o,
    output logic llc_empty_o
);
    int fcnt[NUM_CORES];
    int scnt[NUM_CORES];
    int lcnt;
    int lim;
    // A slow answer keeps the controller waiting several cycles on every handshake.
    assign lim = slow_i ? 4 : 0;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flush_done_o <= '0;
            save_done_o <= '0;
            llc_empty_o <= 1'h0;
            lcnt <= 0;
            foreach (fcnt[i]) fcnt[i] <= 0;
            foreach (scnt[i]) scnt[i] <= 0;
        end
        else
        begin
            for (int i = 0; i < NUM_CORES; i++)
            begin
                fcnt[i] <= (flush_req_i[i] && !flush_done_o[i]) ? fcnt[i] + 1 : 0;
                flush_done_o[i] <= flush_req_i[i] && !flush_done_o[i] && fcnt[i] >= lim;
                scnt[i] <= (save_req_i[i] && !save_done_o[i]) ? scnt[i] + 1 : 0;
                save_done_o[i] <= save_req_i[i] && !save_done_o[i] && scnt[i] >= lim;
            end
            // The cache stays empty only while it is unpowered; otherwise it refills.
            lcnt <= llc_flush_req_i ? lcnt + 1 : 0;
            llc_empty_o <= llc_flush_req_i ? lcnt >= lim : llc_empty_o & llc_pwr_off_i;
        end
    end
endmodule

// File: verification/test_package_power_state_control.sv
// Self-checking bench for the package power state controller.
`timescale 1ns/1ps
module test_package_power_state_control;
    localparam int NC = ppsc_pkg::NUM_CORES;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic slow = 1'h0;
    logic [3*NC-1:0] req = '0;
    logic [NC-1:0] busy = '0;
    logic [NC-1:0] saved = '0;
    logic s_vld = 1'h0, hot = 1'h0, wake = 1'h0, m_idle = 1'h0, m_sr = 1'h0;
    logic m_open = 1'h0, d3 = 1'h0, i_vld = 1'h0, perf = 1'h0;
    logic [1:0] s_req = 2'h0;
    logic [NC-1:0] fl_done, sv_done, fl_req, gate, sv_req, off, irq_tgt;
    logic llc_empty, llc_fl, llc_off, low_vf, pkg_off, reboot, hot_rej, cke;
    logic clk_on, disp, gfx_off, irq_v;
    logic [3*NC-1:0] cst;
    logic [2:0] pkg_cst;
    logic [1:0] slp, mem;
    int error_cnt = 0, num_checks = 0, seed, exp_st[NC];

    always #10 clk_i = ~clk_i;

    ppsc_top #(.NUM_CORES(NC)) ppsc_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .core_req_i(req), .core_flush_done_i(fl_done),
        .core_save_done_i(sv_done), .core_busy_i(busy), .llc_empty_i(llc_empty),
        .sleep_req_valid_i(s_vld), .sleep_req_i(s_req), .s3_hot_req_i(hot), .wake_i(wake),
        .mem_idle_req_i(m_idle), .mem_sr_req_i(m_sr), .banks_open_i(m_open),
        .gfx_d3_i(d3), .irq_valid_i(i_vld), .irq_perf_mode_i(perf), .core_state_o(cst),
        .core_flush_req_o(fl_req), .core_clk_gate_o(gate), .core_save_req_o(sv_req),
        .core_pwr_off_o(off), .llc_flush_req_o(llc_fl), .llc_pwr_off_o(llc_off),
        .low_vf_o(low_vf), .pkg_cstate_o(pkg_cst), .sleep_state_o(slp),
        .pkg_pwr_off_o(pkg_off), .reboot_req_o(reboot), .s3_hot_reject_o(hot_rej),
        .mem_mode_o(mem), .dram_cke_o(cke), .sys_clk_on_o(clk_on), .display_on_o(disp),
        .gfx_pwr_off_o(gfx_off), .irq_valid_o(irq_v), .irq_target_o(irq_tgt));

    ppsc_far_model #(.NUM_CORES(NC)) ppsc_far_model_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .flush_req_i(fl_req),
        .save_req_i(sv_req), .llc_flush_req_i(llc_fl), .llc_pwr_off_i(llc_off),
        .flush_done_o(fl_done), .save_done_o(sv_done), .llc_empty_o(llc_empty));

    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    function automatic logic [3*NC-1:0] want();
        logic [3*NC-1:0] w;
        for (int i = 0; i < NC; i++) w[3*i +: 3] = 3'(exp_st[i]);
        return w;
    endfunction

    // Reference routing: energy mode picks a deep idle core only as core 0 when none is in C0, C1 or C1E, performance prefers halted.
    function automatic int route(input logic p);
        int act = -1, idl = -1, free = -1, sel;
        for (int i = NC - 1; i >= 0; i--)
        begin
            if (exp_st[i] == 0) act = i;
            if (exp_st[i] == 0 && !busy[i]) free = i;
            if (exp_st[i] == 1 || exp_st[i] == 2) idl = i;
        end
        sel = p ? (idl >= 0 ? idl : (free >= 0 ? free : act)) : (act >= 0 ? act : idl);
        return sel < 0 ? 0 : sel;
    endfunction

    task automatic apply();
        int n;
        @(posedge clk_i);
        req <= want();
        slow <= 1'($random(seed));
        #1;
        for (n = 0; n < 60 && cst !== want(); n++) tick(1);
        check(cst, want(), "core states");
    endtask

    // Every change of idle request passes through C0 first, as the sequencer demands.
    task automatic idle();
        foreach (exp_st[i]) exp_st[i] = 0;
        apply();
    endtask

    task automatic irq_power_aware_irq_steering(input logic p);
        @(posedge clk_i);
        i_vld <= 1'h1;
        perf <= p;
        @(posedge clk_i);
        perf <= ~p;
        #1;
        check(irq_v, 1, "irq valid");
        check(irq_tgt, 1 << route(p), "irq target");
        @(posedge clk_i);
        i_vld <= 1'h0;
        #1;
        check(irq_tgt, 1 << route(~p), "second target");
        tick(1);
        check({irq_v, irq_tgt}, 0, "irq idle");
    endtask

    task automatic pulse_sleep(input logic [1:0] s, input logic [1:0] exp, input logic w);
        int n;
        @(posedge clk_i);
        s_vld <= ~w;
        s_req <= s;
        wake <= w;
        @(posedge clk_i);
        s_vld <= 1'h0;
        wake <= 1'h0;
        #1;
        for (n = 0; n < 8 && slp !== exp; n++) tick(1);
        tick(3);
        check(slp, exp, "sleep state");
    endtask

    always @(posedge clk_i)
    begin
        saved <= (saved | (sv_req & sv_done)) & (off | sv_req);
        if (rst_n_i)
        begin
            check(fl_req & gate, 0, "gated in write-back");
            check(off & ~saved, 0, "off before save");
            check(llc_off & ~llc_empty, 0, "cache off early");
            check(cke, mem == 0, "cke level");
        end
    end

    initial
    begin
        seed = 71;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'h1;
        tick(4);
        check({cke, mem, clk_on, disp}, 5'h13, "after reset");
        for (int c = 1; c <= 5; c++)
        begin
            idle();
            exp_st[0] = c;
            apply();
            check(gate[0], 1, "core gated");
            check(off[0], c >= 4, "core off");
            check(llc_fl, 0, "lone core flush");
        end
        for (int c = 1; c <= 6; c++)
        begin
            idle();
            foreach (exp_st[i]) exp_st[i] = (c == 6) ? 5 - (i == 0) : c;
            apply();
            // The package state is resolved from registered core states, one cycle later.
            tick(1);
            for (int n = 0; n < 30 && llc_off !== (c == 5); n++) tick(1);
            check(pkg_cst, c == 6 ? 4 : c, "package state");
            check({low_vf, llc_off, llc_fl}, {c >= 2, c == 5, 1'h0}, "package");
            check({clk_on, disp}, 2'h3, "idle clocks");
        end
        for (int m = 0; m < 8; m++)
        begin
            @(posedge clk_i);
            {m_sr, m_idle, m_open} <= 3'(m);
            tick(2);
            check({mem, cke}, m >= 4 ? 6 : m[1] ? (m[0] ? 4 : 2) : 1, "mem");
        end
        @(posedge clk_i);
        {m_sr, m_idle, m_open} <= 3'h0;
        for (int k = 0; k < 16; k++)
        begin
            idle();
            foreach (exp_st[i]) exp_st[i] = $unsigned($random(seed)) % 4;
            apply();
            @(posedge clk_i);
            busy <= NC'($random(seed));
            irq_power_aware_irq_steering(1'($random(seed)));
        end
        idle();
        @(posedge clk_i);
        hot <= 1'h1;
        d3 <= 1'h1;
        @(posedge clk_i);
        hot <= 1'h0;
        #1;
        check(hot_rej, 1, "hot refused");
        tick(1);
        check({hot_rej, slp}, 0, "hot pulse");
        pulse_sleep(2'h1, 2'h1, 1'h0);
        check({mem, cke, pkg_off, clk_on, disp, gfx_off}, 7'h69, "ram suspend");
        pulse_sleep(2'h2, 2'h1, 1'h0);
        pulse_sleep(2'h0, 2'h0, 1'h1);
        check({disp, gfx_off, pkg_off}, 0, "awake in D3");
        @(posedge clk_i);
        d3 <= 1'h0;
        pulse_sleep(2'h2, 2'h2, 1'h0);
        check({pkg_off, clk_on}, 2'h2, "disk suspend");
        pulse_sleep(2'h0, 2'h0, 1'h1);
        pulse_sleep(2'h3, 2'h3, 1'h0);
        check({pkg_off, reboot}, 2'h3, "soft off");
        pulse_sleep(2'h0, 2'h3, 1'h1);
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'h1;
        tick(4);
        check({slp, reboot, pkg_off}, 0, "after reboot");
        report_and_stop();
    end

    initial
    begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
endmodule
